// [acr_config_regs.sv]
// configuration register bank with shadow commit and per-channel indexing
`timescale 1ns/1ps
`default_nettype none
module acr_config_regs (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire acr_pkg::acr_req_t req,
    output logic [7:0] rdata,
    input wire logic pdwn_pin,
    input wire logic [acr_pkg::DATA_W-1:0] conv_data_a,
    input wire logic [acr_pkg::DATA_W-1:0] conv_data_b,
    input wire logic [acr_pkg::DATA_W-1:0] user_word1,
    input wire logic [acr_pkg::DATA_W-1:0] user_word2,
    output logic [acr_pkg::DATA_W-1:0] out_data_a,
    output logic [acr_pkg::DATA_W-1:0] out_data_b,
    output logic [1:0] chan_power_down,
    output logic [1:0] chan_standby,
    output logic digital_reset,
    output logic dcs_enable,
    output logic clk_div_en,
    output logic self_test_run,
    output logic self_test_restart
);
    // -----------------------------------------
    // storage
    // -----------------------------------------
    logic [1:0] chan_index_r;
    acr_pkg::acr_chan_t shadow_a_r;
    acr_pkg::acr_chan_t shadow_b_r;
    acr_pkg::acr_chan_t active_a_r;
    acr_pkg::acr_chan_t active_b_r;
    logic [7:0] shadow_clock_r;
    logic [7:0] shadow_div_r;
    logic [7:0] active_clock_r;
    logic [7:0] active_div_r;
    logic [7:0] self_test_r;
    logic commit_r;
    logic [2:0] div_cnt_r;
    logic [1:0] pdwn_meta_r;
    logic pdwn_sync;
    logic [1:0] pwr_a;
    logic [1:0] pwr_b;
    logic [1:0] pin_a;
    logic [1:0] pin_b;
    logic commit_wr;
    logic [7:0] rdata_nxt;

    assign commit_wr = req.wr && req.addr == acr_pkg::ADDR_SHADOW_COMMIT
        && req.wdata == acr_pkg::COMMIT_VALUE;

    // -----------------------------------------
    // pin synchroniser
    // -----------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pdwn_meta_r <= 2'b00;
        end else begin
            pdwn_meta_r <= {pdwn_meta_r[0], pdwn_pin};
        end
    end
    assign pdwn_sync = pdwn_meta_r[1];

    // -----------------------------------------
    // channel index
    // -----------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            chan_index_r <= acr_pkg::RST_CHANNEL_INDEX[1:0];
        end else if (req.wr && req.addr == acr_pkg::ADDR_CHANNEL_INDEX) begin
            chan_index_r <= req.wdata[1:0];
        end
    end

    // -----------------------------------------
    // shadow registers
    // -----------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            shadow_a_r <= {acr_pkg::RST_OPERATING_MODE, acr_pkg::RST_OUTPUT_PATTERN_SELECT};
            shadow_b_r <= {acr_pkg::RST_OPERATING_MODE, acr_pkg::RST_OUTPUT_PATTERN_SELECT};
        end else if (req.wr) begin
            // local writes land in every indexed channel
            if (req.addr == acr_pkg::ADDR_OPERATING_MODE) begin
                if (chan_index_r[0]) shadow_a_r.mode <= req.wdata;
                if (chan_index_r[1]) shadow_b_r.mode <= req.wdata;
            end
            if (req.addr == acr_pkg::ADDR_OUTPUT_PATTERN_SELECT) begin
                if (chan_index_r[0]) shadow_a_r.pattern <= req.wdata;
                if (chan_index_r[1]) shadow_b_r.pattern <= req.wdata;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            shadow_clock_r <= acr_pkg::RST_CLOCK_CONDITIONING;
            shadow_div_r <= acr_pkg::RST_INPUT_CLOCK_DIVIDER;
        end else if (req.wr) begin
            if (req.addr == acr_pkg::ADDR_CLOCK_CONDITIONING) begin
                shadow_clock_r <= {7'h00, req.wdata[acr_pkg::CLK_DCS_BIT]};
            end
            if (req.addr == acr_pkg::ADDR_INPUT_CLOCK_DIVIDER) begin
                shadow_div_r <= {5'h00, req.wdata[acr_pkg::DIV_RATIO_LSB +: 3]};
            end
        end
    end

    // -----------------------------------------
    // commit: pulse then autoclear
    // -----------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            commit_r <= acr_pkg::RST_SHADOW_COMMIT[0];
        end else begin
            commit_r <= commit_wr;
        end
    end

    // all shadows move in one edge so settings never mix old and new
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            active_a_r <= {acr_pkg::RST_OPERATING_MODE, acr_pkg::RST_OUTPUT_PATTERN_SELECT};
            active_b_r <= {acr_pkg::RST_OPERATING_MODE, acr_pkg::RST_OUTPUT_PATTERN_SELECT};
            active_clock_r <= acr_pkg::RST_CLOCK_CONDITIONING;
            active_div_r <= acr_pkg::RST_INPUT_CLOCK_DIVIDER;
        end else if (commit_r) begin
            active_a_r <= shadow_a_r;
            active_b_r <= shadow_b_r;
            active_clock_r <= shadow_clock_r;
            active_div_r <= shadow_div_r;
        end
    end

    // -----------------------------------------
    // self-test control, not shadowed
    // -----------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            self_test_r <= acr_pkg::RST_SELF_TEST_CONTROL;
        end else if (req.wr && req.addr == acr_pkg::ADDR_SELF_TEST_CONTROL) begin
            self_test_r <= req.wdata & 8'h05;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            self_test_run <= 1'b0;
            self_test_restart <= 1'b0;
        end else begin
            self_test_run <= self_test_r[acr_pkg::BIST_START_BIT];
            self_test_restart <= self_test_r[acr_pkg::BIST_RESTART_BIT];
        end
    end

    // -----------------------------------------
    // clock divider and stabilizer
    // -----------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_r <= 3'h0;
            clk_div_en <= 1'b0;
        end else if (div_cnt_r >= active_div_r[2:0]) begin
            div_cnt_r <= 3'h0;
            clk_div_en <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 3'h1;
            clk_div_en <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dcs_enable <= 1'b0;
        end else begin
            dcs_enable <= active_clock_r[acr_pkg::CLK_DCS_BIT];
        end
    end

    // -----------------------------------------
    // power modes
    // -----------------------------------------
    // pin, when enabled, forces full down or standby per the pin-function field, except on a channel whose mode is digital reset
    always_comb begin
        pwr_a = active_a_r.mode[acr_pkg::MODE_PWR_LSB +: 2];
        pwr_b = active_b_r.mode[acr_pkg::MODE_PWR_LSB +: 2];
        pin_a = active_a_r.mode[acr_pkg::MODE_PIN_FN_LSB] ? acr_pkg::PWR_STANDBY : acr_pkg::PWR_FULL_DOWN;
        pin_b = active_b_r.mode[acr_pkg::MODE_PIN_FN_LSB] ? acr_pkg::PWR_STANDBY : acr_pkg::PWR_FULL_DOWN;
        if (pdwn_sync && active_a_r.mode[acr_pkg::MODE_PIN_EN_BIT] && pwr_a != acr_pkg::PWR_DIGITAL_RESET) begin
            pwr_a = pin_a;
        end
        if (pdwn_sync && active_b_r.mode[acr_pkg::MODE_PIN_EN_BIT] && pwr_b != acr_pkg::PWR_DIGITAL_RESET) begin
            pwr_b = pin_b;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            chan_power_down <= 2'b00;
            chan_standby <= 2'b00;
            digital_reset <= 1'b0;
        end else begin
            chan_power_down <= {pwr_b == acr_pkg::PWR_FULL_DOWN, pwr_a == acr_pkg::PWR_FULL_DOWN};
            chan_standby <= {pwr_b == acr_pkg::PWR_STANDBY, pwr_a == acr_pkg::PWR_STANDBY};
            digital_reset <= pwr_a == acr_pkg::PWR_DIGITAL_RESET || pwr_b == acr_pkg::PWR_DIGITAL_RESET;
        end
    end

    // -----------------------------------------
    // read-back
    // -----------------------------------------
    // channel A wins when both index bits are set
    always_comb begin
        case (req.addr)
            acr_pkg::ADDR_CHANNEL_INDEX: rdata_nxt = {6'h00, chan_index_r};
            acr_pkg::ADDR_OPERATING_MODE: rdata_nxt = chan_index_r[0] ? shadow_a_r.mode : shadow_b_r.mode;
            acr_pkg::ADDR_OUTPUT_PATTERN_SELECT:
                rdata_nxt = chan_index_r[0] ? shadow_a_r.pattern : shadow_b_r.pattern;
            acr_pkg::ADDR_CLOCK_CONDITIONING: rdata_nxt = shadow_clock_r;
            acr_pkg::ADDR_INPUT_CLOCK_DIVIDER: rdata_nxt = shadow_div_r;
            acr_pkg::ADDR_SELF_TEST_CONTROL: rdata_nxt = self_test_r;
            acr_pkg::ADDR_SHADOW_COMMIT: rdata_nxt = {7'h00, commit_r};
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            rdata <= rdata_nxt;
        end
    end

    // -----------------------------------------
    // per-channel test pattern generators
    // -----------------------------------------
    acr_pattern_gen u_pat_a (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pattern(active_a_r.pattern),
        .user_word1(user_word1),
        .user_word2(user_word2),
        .conv_data(conv_data_a),
        .out_data(out_data_a)
    );

    acr_pattern_gen u_pat_b (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pattern(active_b_r.pattern),
        .user_word1(user_word1),
        .user_word2(user_word2),
        .conv_data(conv_data_b),
        .out_data(out_data_b)
    );
endmodule
`default_nettype wire

// [acr_config_regs_assertions.sv]
// checker: port-level assertions for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module acr_config_regs_assertions (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire acr_pkg::acr_req_t req,
    input wire logic [acr_pkg::DATA_W-1:0] conv_data_a,
    input wire logic [acr_pkg::DATA_W-1:0] out_data_a,
    input wire logic digital_reset,
    input wire logic dcs_enable,
    input wire logic clk_div_en,
    input wire logic self_test_run,
    input wire logic self_test_restart
);
    logic [1:0] idx_r;
    logic [7:0] shd_r;
    logic [7:0] act_r;
    logic [3:0] quiet_r;
    logic [3:0] gap_r;
    logic commit;
    logic st_wr;
    logic settled;
    assign commit = req.wr && req.addr == acr_pkg::ADDR_SHADOW_COMMIT && req.wdata == acr_pkg::COMMIT_VALUE;
    assign st_wr = req.wr && req.addr == acr_pkg::ADDR_SELF_TEST_CONTROL;
    // output lags the commit by a few cycles, so pattern checks wait
    assign settled = quiet_r > 4'h6;

    // ----------------------------------------
    // channel A pattern tracking
    // ----------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            idx_r <= 2'h3;
            shd_r <= 8'h00;
        end else if (req.wr && req.addr == acr_pkg::ADDR_CHANNEL_INDEX) begin
            idx_r <= req.wdata[1:0];
        end else if (req.wr && req.addr == acr_pkg::ADDR_OUTPUT_PATTERN_SELECT && idx_r[0]) begin
            shd_r <= req.wdata;
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            act_r <= 8'h00;
            quiet_r <= 4'h0;
        end else if (commit) begin
            act_r <= shd_r;
            quiet_r <= 4'h0;
        end else if (quiet_r != 4'hF) begin
            quiet_r <= quiet_r + 4'h1;
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) gap_r <= 4'h0;
        else if (clk_div_en) gap_r <= 4'h0;
        else if (gap_r != 4'hF) gap_r <= gap_r + 4'h1;
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    chk_conv_pass: assert property (settled && act_r[3:0] == 4'h0 |-> out_data_a == $past(conv_data_a))
        else $error("output is not the delayed conversion word");
    chk_full_scale: assert property (settled && act_r[3:1] == 3'h1
        |-> out_data_a == (act_r[0] ? 10'h000 : 10'h3FF))
        else $error("full scale word wrong");
    chk_checker_alt: assert property (settled && act_r[3:0] == 4'h4
        |-> (out_data_a ^ $past(out_data_a)) == 10'h3FF)
        else $error("checkerboard does not alternate");
    chk_sync_word: assert property (settled && act_r[3:0] == 4'hA |-> out_data_a == 10'h0F8)
        else $error("sync word wrong");
    chk_prbs_held: assert property (settled && act_r[3:0] == 4'h5 && act_r[5] |-> $stable(out_data_a))
        else $error("long sequence moves while held");
    chk_dcs_commit: assert property ($changed(dcs_enable) |-> quiet_r inside {[4'h1:4'h6]})
        else $error("stabilizer enable changed without commit");
    chk_dreset_commit: assert property ($changed(digital_reset) |-> quiet_r inside {[4'h1:4'h6]})
        else $error("digital reset changed without commit");
    chk_st_start: assert property (st_wr && req.wdata[0] |-> ##[1:3] self_test_run)
        else $error("self test did not start");
    chk_st_restart: assert property (st_wr && req.wdata[2] |-> ##[1:3] self_test_restart)
        else $error("self test restart not raised");
    chk_div_gap: assert property (gap_r < 4'h8)
        else $error("divider pulse gap too long");
endmodule

bind acr_config_regs acr_config_regs_assertions chk_u (
    .mclk(mclk), .sys_rst(sys_rst), .req(req), .conv_data_a(conv_data_a),
    .out_data_a(out_data_a), .digital_reset(digital_reset), .dcs_enable(dcs_enable),
    .clk_div_en(clk_div_en), .self_test_run(self_test_run), .self_test_restart(self_test_restart)
);
`default_nettype wire

// [acr_config_regs_test.sv]
// testbench: register bank scenarios through the host model
`timescale 1ns/1ps
`default_nettype none
module acr_config_regs_test;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic pdwn_pin = 1'b0;
    logic [9:0] conv_a = 10'h000;
    logic [9:0] conv_b = 10'h200;
    logic [9:0] uw1 = 10'h155;
    logic [9:0] uw2 = 10'h0F0;
    acr_pkg::acr_req_t req;
    logic [7:0] rdata;
    logic [9:0] out_a;
    logic [9:0] out_b;
    logic [1:0] pd;
    logic [1:0] sb;
    logic dres, dcs, div_en, st_run, st_rst;
    int bad_count = 0;
    int cmp_count = 0;
    int n;
    logic [9:0] prev;
    // code, check kind (word, step, moving), value
    logic [19:0] tbl [17] = '{20'h023FF, 20'h03000, 20'h01200, 20'h047FF, 20'h077FF, 20'h096AA,
        20'h0C7FF, 20'h0A0F8, 20'h0B200, 20'h08155, 20'h485A5, 20'h88000, 20'hC8000,
        20'h05800, 20'h25400, 20'h06800, 20'h16400};

    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        conv_a <= conv_a + 10'h001;
        conv_b <= conv_b + 10'h003;
    end

    acr_config_regs dut_u (.mclk(mclk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .pdwn_pin(pdwn_pin),
        .conv_data_a(conv_a), .conv_data_b(conv_b), .user_word1(uw1), .user_word2(uw2),
        .out_data_a(out_a), .out_data_b(out_b), .chan_power_down(pd), .chan_standby(sb),
        .digital_reset(dres), .dcs_enable(dcs), .clk_div_en(div_en), .self_test_run(st_run),
        .self_test_restart(st_rst));
    acr_host_model host_u (.mclk(mclk), .req(req), .rdata(rdata));

    task automatic cmp_reg(input string s, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic cmp_port(input string s, input logic [9:0] e, input logic [9:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host_u.rd(a, d);
        cmp_reg($sformatf("reg_%h", a), e, d);
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic set_reg(input logic [7:0] a, input logic [7:0] d);
        host_u.wr(a, d);
        host_u.commit();
        settle(8);
    endtask
    task automatic final_report();
        if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        // ----------------------------------------
        // reset values and unmapped space
        // ----------------------------------------
        rchk(acr_pkg::ADDR_OPERATING_MODE, 8'h80);
        rchk(acr_pkg::ADDR_CLOCK_CONDITIONING, 8'h00);
        rchk(acr_pkg::ADDR_INPUT_CLOCK_DIVIDER, 8'h00);
        rchk(acr_pkg::ADDR_OUTPUT_PATTERN_SELECT, 8'h00);
        rchk(acr_pkg::ADDR_SELF_TEST_CONTROL, 8'h00);
        rchk(acr_pkg::ADDR_SHADOW_COMMIT, 8'h00);
        host_u.wr(8'h30, 8'h55);
        rchk(8'h30, 8'h00);
        cmp_port("power", 10'h000, {5'h00, pd, sb, dres});
        // ----------------------------------------
        // shadowing, then every test code
        // ----------------------------------------
        host_u.wr(acr_pkg::ADDR_OUTPUT_PATTERN_SELECT, 8'h02);
        settle(6);
        cmp_port("out_a", conv_a - 10'h001, out_a);
        rchk(acr_pkg::ADDR_OUTPUT_PATTERN_SELECT, 8'h02);
        foreach (tbl[i]) begin
            set_reg(acr_pkg::ADDR_OUTPUT_PATTERN_SELECT, tbl[i][19:12]);
            prev = out_a;
            settle(0);
            case (tbl[i][11:10])
                2'h0: cmp_port("pat_word", tbl[i][9:0], out_a);
                2'h1: cmp_port("pat_step", tbl[i][9:0], out_a ^ prev);
                default: cmp_port("prbs_step", 10'h000, {9'h000, (out_a ^ prev) == 10'h000});
            endcase
        end
        cmp_port("out_b", 10'h000, out_b ^ prev);
        rchk(acr_pkg::ADDR_SHADOW_COMMIT, 8'h00);
        // ----------------------------------------
        // channel index
        // ----------------------------------------
        host_u.wr(acr_pkg::ADDR_CHANNEL_INDEX, 8'h01);
        host_u.wr(acr_pkg::ADDR_OUTPUT_PATTERN_SELECT, 8'h0B);
        host_u.wr(acr_pkg::ADDR_CHANNEL_INDEX, 8'h02);
        host_u.wr(acr_pkg::ADDR_OUTPUT_PATTERN_SELECT, 8'h0A);
        host_u.wr(acr_pkg::ADDR_CHANNEL_INDEX, 8'h03);
        rchk(acr_pkg::ADDR_OUTPUT_PATTERN_SELECT, 8'h0B);
        host_u.commit();
        settle(8);
        cmp_port("out_a", 10'h200, out_a);
        cmp_port("out_b", 10'h0F8, out_b);
        set_reg(acr_pkg::ADDR_OUTPUT_PATTERN_SELECT, 8'h00);
        cmp_port("out_a", conv_a - 10'h001, out_a);
        // ----------------------------------------
        // power modes and the power-down pin
        // ----------------------------------------
        for (int c = 1; c < 5; c++) begin
            set_reg(acr_pkg::ADDR_OPERATING_MODE, 8'h80 | 8'(c % 4));
            cmp_port("power", {5'h00, {2{c == 1}}, {2{c == 2}}, c == 3}, {5'h00, pd, sb, dres});
        end
        @(posedge mclk);
        pdwn_pin <= 1'b1;
        settle(4);
        cmp_port("pin_down", 10'h018, {5'h00, pd, sb, dres});
        set_reg(acr_pkg::ADDR_OPERATING_MODE, 8'hA0);
        cmp_port("pin_standby", 10'h006, {5'h00, pd, sb, dres});
        set_reg(acr_pkg::ADDR_OPERATING_MODE, 8'h00);
        cmp_port("pin_off", 10'h000, {5'h00, pd, sb, dres});
        @(posedge mclk);
        pdwn_pin <= 1'b0;
        // ----------------------------------------
        // stabilizer, divider, self test
        // ----------------------------------------
        host_u.wr(acr_pkg::ADDR_CLOCK_CONDITIONING, 8'hFF);
        rchk(acr_pkg::ADDR_CLOCK_CONDITIONING, 8'h01);
        settle(6);
        cmp_port("dcs", 10'h000, {9'h000, dcs});
        host_u.commit();
        settle(6);
        cmp_port("dcs", 10'h001, {9'h000, dcs});
        for (int r = 0; r < 8; r = r * 2 + 1) begin
            set_reg(acr_pkg::ADDR_INPUT_CLOCK_DIVIDER, 8'(r));
            n = 0;
            repeat (48) begin
                @(negedge mclk);
                n += int'(div_en === 1'b1);
            end
            cmp_port("div_pulses", 10'(48 / (r + 1)), 10'(n));
        end
        host_u.wr(acr_pkg::ADDR_SELF_TEST_CONTROL, 8'hFF);
        settle(2);
        cmp_port("self_test", 10'h003, {8'h00, st_run, st_rst});
        rchk(acr_pkg::ADDR_SELF_TEST_CONTROL, 8'h05);
        host_u.wr(acr_pkg::ADDR_SELF_TEST_CONTROL, 8'h00);
        settle(2);
        cmp_port("self_test", 10'h000, {8'h00, st_run, st_rst});
        final_report();
    end
endmodule
`default_nettype wire

// [acr_host_model.sv]
// host model: drives register accesses into the bank
`timescale 1ns/1ps
`default_nettype none
module acr_host_model (
    input wire logic mclk,
    output var acr_pkg::acr_req_t req,
    input wire logic [7:0] rdata
);
    initial req = '0;
    // released address and data show inverted values, never stale ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge mclk);
        req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk);
        req <= '{1'b0, 1'b0, ~a, 8'hFF};
        @(posedge mclk);
        d = rdata;
    endtask
    task automatic commit();
        wr(acr_pkg::ADDR_SHADOW_COMMIT, acr_pkg::COMMIT_VALUE);
    endtask
endmodule
`default_nettype wire

// [acr_pattern_gen.sv]
// one channel's output test pattern generator and data multiplexer
`timescale 1ns/1ps
`default_nettype none
module acr_pattern_gen (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] pattern,
    input wire logic [acr_pkg::DATA_W-1:0] user_word1,
    input wire logic [acr_pkg::DATA_W-1:0] user_word2,
    input wire logic [acr_pkg::DATA_W-1:0] conv_data,
    output logic [acr_pkg::DATA_W-1:0] out_data
);
    logic [22:0] long_lfsr_r;
    logic [8:0] short_lfsr_r;
    logic phase_r;
    logic user_done_r;
    logic [3:0] sel;
    logic [1:0] user_seq;
    logic [acr_pkg::DATA_W-1:0] test_word;
    logic [acr_pkg::DATA_W-1:0] user_word;

    assign sel = pattern[acr_pkg::PAT_SEL_LSB +: 4];
    assign user_seq = pattern[acr_pkg::PAT_USER_SEQ_LSB +: 2];

    // -----------------------------------------
    // pseudo-random generators
    // -----------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            long_lfsr_r <= 23'h7FFFFF;
        end else if (pattern[acr_pkg::PAT_RST_LONG_BIT]) begin
            long_lfsr_r <= 23'h7FFFFF;
        end else begin
            long_lfsr_r <= {long_lfsr_r[21:0], long_lfsr_r[22] ^ long_lfsr_r[17]};
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            short_lfsr_r <= 9'h1FF;
        end else if (pattern[acr_pkg::PAT_RST_SHORT_BIT]) begin
            short_lfsr_r <= 9'h1FF;
        end else begin
            short_lfsr_r <= {short_lfsr_r[7:0], short_lfsr_r[8] ^ short_lfsr_r[4]};
        end
    end

    // -----------------------------------------
    // alternating phase and user sequencing
    // -----------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
        end
    end

    // "once" modes stop after one pass; leaving user mode rearms
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            user_done_r <= 1'b0;
        end else if (sel != acr_pkg::PAT_USER) begin
            user_done_r <= 1'b0;
        end else if (user_seq[1] && (!user_seq[0] || phase_r)) begin
            user_done_r <= 1'b1;
        end
    end

    always_comb begin
        user_word = (user_seq[0] && phase_r) ? user_word2 : user_word1;
        if (user_done_r) begin
            user_word = '0;
        end
    end

    // -----------------------------------------
    // pattern select
    // -----------------------------------------
    always_comb begin
        case (sel)
            acr_pkg::PAT_MIDSCALE: test_word = {1'b1, {(acr_pkg::DATA_W-1){1'b0}}};
            acr_pkg::PAT_POS_FULL_SCALE: test_word = '1;
            acr_pkg::PAT_NEG_FULL_SCALE: test_word = '0;
            acr_pkg::PAT_CHECKER: test_word = phase_r ? 10'h2AA : 10'h155;
            acr_pkg::PAT_LONG_PRBS: test_word = long_lfsr_r[acr_pkg::DATA_W-1:0];
            acr_pkg::PAT_SHORT_PRBS: test_word = {short_lfsr_r, short_lfsr_r[8]};
            acr_pkg::PAT_WORD_TOGGLE: test_word = phase_r ? '1 : '0;
            acr_pkg::PAT_USER: test_word = user_word;
            acr_pkg::PAT_BIT_TOGGLE: test_word = phase_r ? 10'h2AA : 10'h000;
            acr_pkg::PAT_SYNC: test_word = 10'h0F8;
            acr_pkg::PAT_ONE_BIT_HIGH: test_word = 10'h200;
            acr_pkg::PAT_MIXED_FREQ: test_word = phase_r ? 10'h343 : 10'h0BC;
            default: test_word = '0;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            out_data <= '0;
        end else if (sel != acr_pkg::PAT_OFF) begin
            out_data <= test_word;
        end else begin
            out_data <= conv_data;
        end
    end
endmodule
`default_nettype wire

// [acr_pkg.sv]
// package: register map, field layout and reset values of the converter configuration bank
package acr_pkg;
    localparam logic [7:0] ADDR_CHANNEL_INDEX = 8'h05;
    localparam logic [7:0] ADDR_OPERATING_MODE = 8'h08;
    localparam logic [7:0] ADDR_CLOCK_CONDITIONING = 8'h09;
    localparam logic [7:0] ADDR_INPUT_CLOCK_DIVIDER = 8'h0B;
    localparam logic [7:0] ADDR_OUTPUT_PATTERN_SELECT = 8'h0D;
    localparam logic [7:0] ADDR_SELF_TEST_CONTROL = 8'h0E;
    localparam logic [7:0] ADDR_SHADOW_COMMIT = 8'hFF;

    localparam logic [7:0] RST_CHANNEL_INDEX = 8'h03;
    localparam logic [7:0] RST_OPERATING_MODE = 8'h80;
    localparam logic [7:0] RST_CLOCK_CONDITIONING = 8'h00;
    localparam logic [7:0] RST_INPUT_CLOCK_DIVIDER = 8'h00;
    localparam logic [7:0] RST_OUTPUT_PATTERN_SELECT = 8'h00;
    localparam logic [7:0] RST_SELF_TEST_CONTROL = 8'h00;
    localparam logic [7:0] RST_SHADOW_COMMIT = 8'h00;
    localparam logic [7:0] COMMIT_VALUE = 8'h01;

    localparam int MODE_PWR_LSB = 0;
    localparam int MODE_PIN_FN_LSB = 5;
    localparam int MODE_PIN_EN_BIT = 7;
    localparam int CLK_DCS_BIT = 0;
    localparam int DIV_RATIO_LSB = 0;
    localparam int PAT_SEL_LSB = 0;
    localparam int PAT_RST_SHORT_BIT = 4;
    localparam int PAT_RST_LONG_BIT = 5;
    localparam int PAT_USER_SEQ_LSB = 6;
    localparam int BIST_START_BIT = 0;
    localparam int BIST_RESTART_BIT = 2;

    localparam int DATA_W = 10;

    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_FULL_DOWN = 2'b01,
        PWR_STANDBY = 2'b10,
        PWR_DIGITAL_RESET = 2'b11
    } acr_pwr_t;

    typedef enum logic [3:0] {
        PAT_OFF = 4'b0000,
        PAT_MIDSCALE = 4'b0001,
        PAT_POS_FULL_SCALE = 4'b0010,
        PAT_NEG_FULL_SCALE = 4'b0011,
        PAT_CHECKER = 4'b0100,
        PAT_LONG_PRBS = 4'b0101,
        PAT_SHORT_PRBS = 4'b0110,
        PAT_WORD_TOGGLE = 4'b0111,
        PAT_USER = 4'b1000,
        PAT_BIT_TOGGLE = 4'b1001,
        PAT_SYNC = 4'b1010,
        PAT_ONE_BIT_HIGH = 4'b1011,
        PAT_MIXED_FREQ = 4'b1100
    } acr_pat_t;

    // one serial-port access as decoded by the framing logic
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acr_req_t;

    // per-channel active settings
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] pattern;
    } acr_chan_t;
endpackage
